// ==== rtl/lsd_delay_line.sv ====
`timescale 1ns/1ps
// ==========================================
// Programmable delay of a single pulse, 0..31 enable ticks
module lsd_delay_line
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic pulseIn,
  input wire logic [7:0] delaySel,
  output logic pulseOut
);
  logic [31:0] shift_ff;
  logic [31:0] nxt_shift;
  logic pend_ff;
  logic nxt_pend;
  logic pulseAny;
  logic pulseOut_ff;
  logic nxt_pulseOut;
  // A pulse between ticks waits for the next tick, so a slow tick never loses it
  assign pulseAny = pulseIn || pend_ff;
  always_comb
  begin
    nxt_shift = shift_ff;
    nxt_pend = pulseAny && !tick;
    if (tick)
    begin
      nxt_shift = {shift_ff[30:0], pulseAny};
    end
    if (delaySel == 8'h00)
    begin
      nxt_pulseOut = pulseAny && tick;
    end
    else
    begin
      nxt_pulseOut = tick && shift_ff[delaySel[4:0] - 5'h01];
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      shift_ff <= 32'h0000_0000;
      pend_ff <= 1'b0;
      pulseOut_ff <= 1'b0;
    end
    else
    begin
      shift_ff <= nxt_shift;
      pend_ff <= nxt_pend;
      pulseOut_ff <= nxt_pulseOut;
    end
  end
  assign pulseOut = pulseOut_ff;
endmodule : lsd_delay_line

// ==== rtl/lsd_pkg.sv ====
package lsd_pkg;
  // ==========================================
  // Register indices (printed offsets; byte address is four times)
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h021;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h025;
  localparam logic [11:0] IDX_TOLERANCE = 12'h034;
  localparam logic [11:0] IDX_CONTROL = 12'h03A;
  localparam logic [11:0] IDX_STATUS = 12'h03B;
  localparam logic [11:0] IDX_SUBCLASS = 12'h301;
  localparam logic [11:0] IDX_MF_DELAY = 12'h304;
  localparam logic [11:0] IDX_BUF_VAR = 12'h306;
  localparam logic [11:0] IDX_LINK_PARAM = 12'h458;
  localparam logic [11:0] IDX_FRAME_CFG = 12'h454;
  // ==========================================
  // Field positions
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_ARM_BIT = 6;
  localparam int CTL_CLEAR_BIT = 5;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_ROTATE_BIT = 2;
  localparam int ST_WINDOW_BIT = 1;
  localparam int ST_EDGE_BIT = 0;
  localparam int LINK_SUBCLASS_LSB = 5;
  // ==========================================
  // Mode codes and limits
  localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h2;
  localparam logic [3:0] MODE_MONITOR = 4'h9;
  localparam logic [2:0] SUBCLASS_ZERO = 3'h0;
  localparam logic [2:0] SUBCLASS_ONE = 3'h1;
  localparam logic [7:0] BUF_DELAY_MAX = 8'h0A;
  localparam logic [7:0] OCTETS_ONE = 8'h00;
  localparam logic [7:0] OCTETS_TWO = 8'h01;
  localparam logic [5:0] FRAMES_PER_MF = 6'h20;
  localparam logic [3:0] DAC_PER_FRAME = 4'h4;
  localparam logic [3:0] ROTATE_CYCLES = 4'h8;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_TOLERANCE = 8'h00;
  localparam logic [7:0] RESET_LINK_PARAM = 8'h00;
  localparam logic [7:0] RESET_FRAME_CFG = 8'h01;
  localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;
  typedef enum logic [1:0] {
    LSD_IDLE = 2'b00,
    LSD_WAIT = 2'b01,
    LSD_ROTATE = 2'b11,
    LSD_MONITOR = 2'b10
  } lsd_state_type;
endpackage : lsd_pkg

// ==== rtl/lsd_sync_core.sv ====
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Contract
// - Mode field codes: 1 one-shot, 2 continuous, 9 one-shot then monitor.
// - Tolerance code 0 means half a DAC clock, 1..7 that many clocks.
// - Writing align_enable starts alignment processing.
// - One-shot: align_arm makes the next edge get a phase check.
// - align_in_progress is high while processing, low when idle.
// - phase_aligned_flag set when in phase, refreshed each check.
// - phase_out_of_window tracks error above tolerance each check.
// - clock_rotated_sticky latches on rotation until sticky_clear.
// - edge_seen_sticky latches on each check until sticky_clear.
// - Four events enabled by one register, read and cleared in another.
// - Only Subclass 0 and 1; subclass held in two registers.
// - No link_sync_out error reporting in Subclass 0 with F of one.
// - Local multiframe clock delayed by local_mf_delay frame clocks.
// - Receive buffer delay 0..10 processing clocks from register.
// - frames_per_proc_clock equals four divided by octets per frame.
// - One-shot checks first edge after arming, rotates only if outside window.
// - Continuous checks every edge, ignoring edges during rotation.
// - Monitor aligns once, then only measures later edges.
// - SYSREF active high, sampled on rising device clock.
module lsd_sync_core
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysrefIn,
  input wire logic linkErrorIn,
  output logic linkSyncOutN,
  output logic localMfClk,
  output logic bufferReadStart,
  output logic alignInProgress
);
  // ==========================================
  // Registers
  logic [7:0] irqEnable_ff, nxt_irqEnable;
  logic [7:0] irqStatus_ff, nxt_irqStatus;
  logic [7:0] tolerance_ff, nxt_tolerance;
  logic [7:0] control_ff, nxt_control;
  logic [7:0] subclass_ff, nxt_subclass;
  logic [7:0] mfDelay_ff, nxt_mfDelay;
  logic [7:0] bufVar_ff, nxt_bufVar;
  logic [7:0] linkParam_ff, nxt_linkParam;
  logic [7:0] frameCfg_ff, nxt_frameCfg;
  logic [31:0] prdata_ff, nxt_prdata;
  logic lock_ff, nxt_lock, window_ff, nxt_window;
  logic rotSticky_ff, nxt_rotSticky, edgeSticky_ff, nxt_edgeSticky;
  lsd_pkg::lsd_state_type state_ff, nxt_state;
  logic [3:0] rotCnt_ff, nxt_rotCnt;
  logic [3:0] dacCnt_ff, nxt_dacCnt;
  logic [4:0] frameCnt_ff, nxt_frameCnt;
  logic [1:0] procCnt_ff, nxt_procCnt;
  logic sysMeta_ff, sysSync_ff, sysPrev_ff;
  logic syncOutN_ff, nxt_syncOutN;
  logic [11:0] regIdx;
  logic wrEn, rdEn, clearStky, sysEdge, alignEdge, checkNow, rotateNow;
  logic [3:0] phaseErr;
  logic [6:0] mfPos, mfDist;
  logic outOfWindow, inPhase, frameTick, procTick, mfEdge, errReport;
  logic [3:0] events;
  assign regIdx = paddr[13:2];
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // ==========================================
  // SYSREF input: two flops, then rising-edge detect
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sysMeta_ff <= 1'b0;
      sysSync_ff <= 1'b0;
      sysPrev_ff <= 1'b0;
    end
    else
    begin
      sysMeta_ff <= sysrefIn;
      sysSync_ff <= sysMeta_ff;
      sysPrev_ff <= sysSync_ff;
    end
  end
  assign sysEdge = sysSync_ff && !sysPrev_ff;
  // ==========================================
  // Frame and processing clock enables
  assign frameTick = (dacCnt_ff == lsd_pkg::DAC_PER_FRAME - 4'h1);
  // One processing clock covers 4/F frames, so F octets-1 selects the stride
  assign procTick = frameTick && (procCnt_ff == (frameCfg_ff == lsd_pkg::OCTETS_ONE ? 2'h3 :
                    frameCfg_ff == lsd_pkg::OCTETS_TWO ? 2'h1 : 2'h0));
  assign mfEdge = frameTick && (frameCnt_ff == 5'h1F);
  // Subclass 0 aligns to the internal processing clock
  assign alignEdge = (subclass_ff[2:0] == lsd_pkg::SUBCLASS_ONE) ? sysEdge : procTick;
  // Phase error in DAC clocks from the nearest multiframe boundary, saturated
  assign mfPos = {frameCnt_ff, dacCnt_ff[1:0]};
  assign mfDist = mfPos[6] ? (7'h00 - mfPos) : mfPos;
  assign phaseErr = (mfDist > 7'h0F) ? 4'hF : mfDist[3:0];
  assign inPhase = (frameCnt_ff == 5'h00) && (dacCnt_ff == 4'h0);
  // Code zero allows half a clock, so only exact phase passes
  assign outOfWindow = (tolerance_ff[2:0] == 3'h0) ? !inPhase : (phaseErr > {1'b0, tolerance_ff[2:0]});
  // ==========================================
  // Alignment sequencer
  always_comb
  begin
    nxt_state = state_ff;
    checkNow = 1'b0;
    rotateNow = 1'b0;
    nxt_rotCnt = rotCnt_ff;
    if (!control_ff[lsd_pkg::CTL_ENABLE_BIT])
    begin
      nxt_state = lsd_pkg::LSD_IDLE;
    end
    else
    begin
      case (state_ff)
        lsd_pkg::LSD_IDLE:
        begin
          if (control_ff[3:0] == lsd_pkg::MODE_CONTINUOUS)
          begin
            nxt_state = lsd_pkg::LSD_WAIT;
          end
          else if (control_ff[lsd_pkg::CTL_ARM_BIT] &&
                   (control_ff[3:0] == lsd_pkg::MODE_ONE_SHOT ||
                    control_ff[3:0] == lsd_pkg::MODE_MONITOR))
          begin
            nxt_state = lsd_pkg::LSD_WAIT;
          end
        end
        lsd_pkg::LSD_WAIT:
        begin
          if (alignEdge)
          begin
            checkNow = 1'b1;
            if (outOfWindow)
            begin
              rotateNow = 1'b1;
              nxt_rotCnt = lsd_pkg::ROTATE_CYCLES;
              nxt_state = lsd_pkg::LSD_ROTATE;
            end
            else if (control_ff[3:0] == lsd_pkg::MODE_MONITOR)
            begin
              nxt_state = lsd_pkg::LSD_MONITOR;
            end
            else if (control_ff[3:0] != lsd_pkg::MODE_CONTINUOUS)
            begin
              nxt_state = lsd_pkg::LSD_IDLE;
            end
          end
        end
        lsd_pkg::LSD_ROTATE:
        begin
          // Edges arriving here are dropped
          nxt_rotCnt = rotCnt_ff - 4'h1;
          if (rotCnt_ff == 4'h1)
          begin
            nxt_state = (control_ff[3:0] == lsd_pkg::MODE_CONTINUOUS) ? lsd_pkg::LSD_WAIT :
                        (control_ff[3:0] == lsd_pkg::MODE_MONITOR) ? lsd_pkg::LSD_MONITOR :
                        lsd_pkg::LSD_IDLE;
          end
        end
        lsd_pkg::LSD_MONITOR:
        begin
          checkNow = alignEdge;
        end
        default:
        begin
          nxt_state = lsd_pkg::LSD_IDLE;
        end
      endcase
    end
  end
  // Monitor keeps reporting but is not busy adjusting
  assign alignInProgress = (state_ff == lsd_pkg::LSD_WAIT) || (state_ff == lsd_pkg::LSD_ROTATE);
  // ==========================================
  // Counters: rotation restarts the local phase at a boundary
  always_comb
  begin
    nxt_dacCnt = frameTick ? 4'h0 : dacCnt_ff + 4'h1;
    nxt_frameCnt = frameTick ? frameCnt_ff + 5'h01 : frameCnt_ff;
    nxt_procCnt = procTick ? 2'h0 : (frameTick ? procCnt_ff + 2'h1 : procCnt_ff);
    if (rotateNow)
    begin
      nxt_dacCnt = 4'h1;
      nxt_frameCnt = 5'h00;
      nxt_procCnt = 2'h0;
    end
  end
  // ==========================================
  // Status flags
  always_comb
  begin
    clearStky = wrEn && (regIdx == lsd_pkg::IDX_CONTROL) && pwdata[lsd_pkg::CTL_CLEAR_BIT];
    nxt_lock = checkNow ? !outOfWindow || (state_ff == lsd_pkg::LSD_WAIT && !outOfWindow) : lock_ff;
    if (rotateNow)
    begin
      nxt_lock = 1'b1;
    end
    nxt_window = checkNow ? outOfWindow : window_ff;
    nxt_rotSticky = (rotSticky_ff && !clearStky) || rotateNow;
    nxt_edgeSticky = (edgeSticky_ff && !clearStky) || checkNow;
  end
  assign events = {nxt_lock && !lock_ff, rotateNow, checkNow, checkNow && outOfWindow};
  // ==========================================
  // Link sync error reporting
  assign errReport = !((subclass_ff[2:0] == lsd_pkg::SUBCLASS_ZERO) &&
                       (frameCfg_ff == lsd_pkg::OCTETS_ONE));
  assign nxt_syncOutN = !(linkErrorIn && errReport);
  // ==========================================
  // APB register file
  always_comb
  begin
    nxt_irqEnable = irqEnable_ff;
    nxt_tolerance = tolerance_ff;
    nxt_control = control_ff;
    nxt_subclass = subclass_ff;
    nxt_mfDelay = mfDelay_ff;
    nxt_bufVar = bufVar_ff;
    nxt_linkParam = linkParam_ff;
    nxt_frameCfg = frameCfg_ff;
    nxt_irqStatus = irqStatus_ff;
    if (state_ff == lsd_pkg::LSD_WAIT && alignEdge)
    begin
      nxt_control[lsd_pkg::CTL_ARM_BIT] = 1'b0;
    end
    nxt_control[lsd_pkg::CTL_CLEAR_BIT] = 1'b0;
    if (wrEn)
    begin
      case (regIdx)
        lsd_pkg::IDX_IRQ_ENABLE: nxt_irqEnable = {4'h0, pwdata[3:0]};
        lsd_pkg::IDX_IRQ_STATUS: nxt_irqStatus = irqStatus_ff & ~pwdata[7:0];
        lsd_pkg::IDX_TOLERANCE: nxt_tolerance = {5'h00, pwdata[2:0]};
        lsd_pkg::IDX_CONTROL: nxt_control = {pwdata[7:6], 1'b0, 1'b0, pwdata[3:0]};
        lsd_pkg::IDX_SUBCLASS: nxt_subclass = {5'h00, pwdata[2:0]};
        lsd_pkg::IDX_MF_DELAY: nxt_mfDelay = pwdata[7:0];
        lsd_pkg::IDX_BUF_VAR: nxt_bufVar = (pwdata[7:0] > lsd_pkg::BUF_DELAY_MAX) ?
                                lsd_pkg::BUF_DELAY_MAX : pwdata[7:0];
        lsd_pkg::IDX_LINK_PARAM: nxt_linkParam = pwdata[7:0];
        lsd_pkg::IDX_FRAME_CFG: nxt_frameCfg = pwdata[7:0];
        default: nxt_irqEnable = irqEnable_ff;
      endcase
    end
    // Set wins over the write-one clear
    nxt_irqStatus = nxt_irqStatus | {4'h0, events & irqEnable_ff[3:0]};
    nxt_prdata = prdata_ff;
    if (rdEn)
    begin
      case (regIdx)
        lsd_pkg::IDX_IRQ_ENABLE: nxt_prdata = {24'h0, irqEnable_ff};
        lsd_pkg::IDX_IRQ_STATUS: nxt_prdata = {24'h0, irqStatus_ff};
        lsd_pkg::IDX_TOLERANCE: nxt_prdata = {24'h0, tolerance_ff};
        lsd_pkg::IDX_CONTROL: nxt_prdata = {24'h0, control_ff};
        lsd_pkg::IDX_STATUS: nxt_prdata = {24'h0, alignInProgress, 3'h0, lock_ff,
                                           rotSticky_ff, window_ff, edgeSticky_ff};
        lsd_pkg::IDX_SUBCLASS: nxt_prdata = {24'h0, subclass_ff};
        lsd_pkg::IDX_MF_DELAY: nxt_prdata = {24'h0, mfDelay_ff};
        lsd_pkg::IDX_BUF_VAR: nxt_prdata = {24'h0, bufVar_ff};
        lsd_pkg::IDX_LINK_PARAM: nxt_prdata = {24'h0, linkParam_ff};
        lsd_pkg::IDX_FRAME_CFG: nxt_prdata = {24'h0, frameCfg_ff};
        default: nxt_prdata = lsd_pkg::PSLVERR_NONE;
      endcase
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irqEnable_ff <= lsd_pkg::RESET_ZERO;
      irqStatus_ff <= lsd_pkg::RESET_ZERO;
      tolerance_ff <= lsd_pkg::RESET_TOLERANCE;
      control_ff <= lsd_pkg::RESET_ZERO;
      subclass_ff <= lsd_pkg::RESET_ZERO;
      mfDelay_ff <= lsd_pkg::RESET_ZERO;
      bufVar_ff <= lsd_pkg::RESET_ZERO;
      linkParam_ff <= lsd_pkg::RESET_LINK_PARAM;
      frameCfg_ff <= lsd_pkg::RESET_FRAME_CFG;
      prdata_ff <= 32'h0000_0000;
      lock_ff <= 1'b0;
      window_ff <= 1'b0;
      rotSticky_ff <= 1'b0;
      edgeSticky_ff <= 1'b0;
      state_ff <= lsd_pkg::LSD_IDLE;
      rotCnt_ff <= 4'h0;
      dacCnt_ff <= 4'h0;
      frameCnt_ff <= 5'h00;
      procCnt_ff <= 2'h0;
      syncOutN_ff <= 1'b1;
    end
    else
    begin
      irqEnable_ff <= nxt_irqEnable;
      irqStatus_ff <= nxt_irqStatus;
      tolerance_ff <= nxt_tolerance;
      control_ff <= nxt_control;
      subclass_ff <= nxt_subclass;
      mfDelay_ff <= nxt_mfDelay;
      bufVar_ff <= nxt_bufVar;
      linkParam_ff <= nxt_linkParam;
      frameCfg_ff <= nxt_frameCfg;
      prdata_ff <= nxt_prdata;
      lock_ff <= nxt_lock;
      window_ff <= nxt_window;
      rotSticky_ff <= nxt_rotSticky;
      edgeSticky_ff <= nxt_edgeSticky;
      state_ff <= nxt_state;
      rotCnt_ff <= nxt_rotCnt;
      dacCnt_ff <= nxt_dacCnt;
      frameCnt_ff <= nxt_frameCnt;
      procCnt_ff <= nxt_procCnt;
      syncOutN_ff <= nxt_syncOutN;
    end
  end
  assign prdata = prdata_ff;
  assign linkSyncOutN = syncOutN_ff;
  // ==========================================
  // Local multiframe clock and buffer release
  lsd_delay_line uMfDelay
  (
    .core_clk(core_clk),
    .reset(reset),
    .tick(frameTick),
    .pulseIn(mfEdge),
    .delaySel({3'h0, mfDelay_ff[4:0]}),
    .pulseOut(localMfClk)
  );
  lsd_delay_line uBufDelay
  (
    .core_clk(core_clk),
    .reset(reset),
    .tick(procTick),
    .pulseIn(localMfClk),
    .delaySel(bufVar_ff),
    .pulseOut(bufferReadStart)
  );
  // ==========================================
  // Checks
  a_sticky_set_wins: assert property (@(posedge core_clk) disable iff (reset)
    checkNow |=> edgeSticky_ff) else $error("edge sticky not set");
  a_rotate_sticky: assert property (@(posedge core_clk) disable iff (reset)
    rotateNow |=> rotSticky_ff) else $error("rotate sticky not set");
  a_window_flag: assert property (@(posedge core_clk) disable iff (reset)
    checkNow |=> window_ff == $past(outOfWindow)) else $error("window flag wrong");
  a_rotate_busy: assert property (@(posedge core_clk) disable iff (reset)
    rotateNow |=> alignInProgress [*7]) else $error("busy dropped in rotation");
  a_no_rotate_monitor: assert property (@(posedge core_clk) disable iff (reset)
    (state_ff == lsd_pkg::LSD_MONITOR) && !frameTick |=> dacCnt_ff == $past(dacCnt_ff) + 4'h1)
    else $error("monitor rotated");
  a_sync_mask: assert property (@(posedge core_clk) disable iff (reset)
    !errReport |=> linkSyncOutN) else $error("sync error reported");
  a_buf_limit: assert property (@(posedge core_clk) disable iff (reset)
    bufVar_ff <= lsd_pkg::BUF_DELAY_MAX) else $error("buffer delay over limit");
  a_stky_clear: assert property (@(posedge core_clk) disable iff (reset)
    clearStky && !checkNow |=> !edgeSticky_ff) else $error("sticky not cleared");
endmodule : lsd_sync_core

// ==== verif/lmfc_sync_and_link_delay_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module lmfc_sync_and_link_delay_tb_top;
  logic core_clk, reset, psel, penable, pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sysrefIn, linkErrorIn, linkSyncOutN;
  logic localMfClk, bufferReadStart, alignInProgress;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;

  lsd_sync_core uut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysrefIn(sysrefIn), .linkErrorIn(linkErrorIn),
    .linkSyncOutN(linkSyncOutN), .localMfClk(localMfClk), .bufferReadStart(bufferReadStart),
    .alignInProgress(alignInProgress));
  lsd_far_end far (.core_clk(core_clk), .sysrefIn(sysrefIn), .linkErrorIn(linkErrorIn));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ==========================================
  // Verdict and hang guard
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      conclude();
    end
  end

  // ==========================================
  // Register access
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                     output logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, rd);
  endtask : wr

  task automatic rdchk(input logic [11:0] idx, input logic [7:0] mask, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, rd);
    `CHK("register", e, rd[7:0] & mask)
  endtask : rdchk

  // Alignment takes a sync delay plus rotation, so give it room
  task automatic edge_and_settle(input int unsigned ph);
    far.edge_at(ph);
    repeat (24) @(posedge core_clk);
  endtask : edge_and_settle

  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [11:0] idx [6];
    logic [7:0] val [6];
    idx = '{lsd_pkg::IDX_TOLERANCE, lsd_pkg::IDX_IRQ_ENABLE, lsd_pkg::IDX_SUBCLASS,
            lsd_pkg::IDX_LINK_PARAM, lsd_pkg::IDX_MF_DELAY, lsd_pkg::IDX_BUF_VAR};
    // Host figures: ((30-1)*2)%32 frames, (34+1)-(30-1) proc clocks
    val = '{8'h07, 8'h0F, 8'h01, 8'h20, 8'h1A, 8'h06};
    rdchk(lsd_pkg::IDX_STATUS, 8'hFF, 8'h00);
    rdchk(lsd_pkg::IDX_FRAME_CFG, 8'hFF, 8'h01);
    for (int i = 0; i < 6; i++)
      wr(idx[i], val[i]);
    for (int i = 0; i < 6; i++)
      rdchk(idx[i], 8'hFF, val[i]);
    `CHK("upper bits", 24'h000000, rd[31:8])
    wr(12'h3FF, 8'h5A);
    rdchk(12'h3FF, 8'hFF, 8'h00);
  endtask : t_regs

  task automatic t_oneshot();
    wr(lsd_pkg::IDX_TOLERANCE, 8'h00);
    wr(lsd_pkg::IDX_CONTROL, 8'h81);
    wr(lsd_pkg::IDX_CONTROL, 8'hC1);
    repeat (2) @(negedge core_clk);
    `CHK("busy armed", 1'b1, alignInProgress)
    edge_and_settle(0);
    `CHK("busy done", 1'b0, alignInProgress)
    rdchk(lsd_pkg::IDX_CONTROL, 8'hCF, 8'h81);
    rdchk(lsd_pkg::IDX_STATUS, 8'h81, 8'h01);
    wr(lsd_pkg::IDX_CONTROL, 8'hA1);
    rdchk(lsd_pkg::IDX_STATUS, 8'h05, 8'h00);
    edge_and_settle(0);
    rdchk(lsd_pkg::IDX_STATUS, 8'h01, 8'h00);
  endtask : t_oneshot

  task automatic t_continuous();
    wr(lsd_pkg::IDX_IRQ_ENABLE, 8'h0F);
    wr(lsd_pkg::IDX_CONTROL, 8'hA2);
    wr(lsd_pkg::IDX_IRQ_STATUS, 8'h0F);
    edge_and_settle(0);
    edge_and_settle(0);
    rdchk(lsd_pkg::IDX_STATUS, 8'h0B, 8'h09);
    edge_and_settle(64);
    rdchk(lsd_pkg::IDX_STATUS, 8'h06, 8'h06);
    rdchk(lsd_pkg::IDX_IRQ_STATUS, 8'h06, 8'h06);
    edge_and_settle(64);
    rdchk(lsd_pkg::IDX_STATUS, 8'h0E, 8'h0C);
    wr(lsd_pkg::IDX_IRQ_STATUS, 8'h0F);
    rdchk(lsd_pkg::IDX_IRQ_STATUS, 8'h06, 8'h00);
    wr(lsd_pkg::IDX_CONTROL, 8'hA2);
    rdchk(lsd_pkg::IDX_STATUS, 8'h05, 8'h00);
  endtask : t_continuous

  task automatic t_monitor();
    wr(lsd_pkg::IDX_CONTROL, 8'hA9);
    wr(lsd_pkg::IDX_CONTROL, 8'hC9);
    edge_and_settle(64);
    edge_and_settle(64);
    rdchk(lsd_pkg::IDX_STATUS, 8'h0B, 8'h09);
    wr(lsd_pkg::IDX_CONTROL, 8'hA9);
    // Off-phase edges are reported but never corrected here
    edge_and_settle(0);
    edge_and_settle(0);
    rdchk(lsd_pkg::IDX_STATUS, 8'h87, 8'h03);
  endtask : t_monitor

  task automatic t_subclass0();
    int lows;
    wr(lsd_pkg::IDX_CONTROL, 8'h00);
    wr(lsd_pkg::IDX_SUBCLASS, 8'h00);
    wr(lsd_pkg::IDX_LINK_PARAM, 8'h00);
    for (int f = 0; f < 2; f++)
    begin
      wr(lsd_pkg::IDX_FRAME_CFG, f[7:0]);
      far.set_error(1'b1);
      lows = 0;
      repeat (300) @(negedge core_clk) lows += (linkSyncOutN !== 1'b1);
      far.set_error(1'b0);
      `CHK("error report", f == 1, lows != 0)
      repeat (20) @(posedge core_clk);
    end
  endtask : t_subclass0

  task automatic wait_hi(input bit useBuf, output int t);
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while ((useBuf ? bufferReadStart : localMfClk) !== 1'b1 && n < 400);
    // A pulse that never comes counts against the run
    if ((useBuf ? bufferReadStart : localMfClk) !== 1'b1)
      failures++;
    t = cyc;
  endtask : wait_hi

  task automatic meas(input logic [7:0] dly, input logic [7:0] bvar, input logic [7:0] fcfg,
                      output int per, output int ph, output int gap);
    int t0, t1, t2;
    wr(lsd_pkg::IDX_MF_DELAY, dly);
    wr(lsd_pkg::IDX_BUF_VAR, bvar);
    wr(lsd_pkg::IDX_FRAME_CFG, fcfg);
    repeat (300) @(posedge core_clk);
    wait_hi(1'b0, t0);
    ph = far.phase;
    wait_hi(1'b1, t1);
    wait_hi(1'b0, t2);
    per = t2 - t0;
    gap = t1 - t0;
  endtask : meas

  task automatic t_delays();
    int per, ph0, ph5, ph26, g0, g10, g15, h0, h5, x;
    meas(8'h00, 8'h00, 8'h01, per, ph0, x);
    `CHK("multiframe period", 128, per)
    // Same local delay for both buffer runs, so the proc clock phase matches
    meas(8'h05, 8'h00, 8'h01, per, ph5, g0);
    `CHK("local delay", 20, (ph5 - ph0 + 128) % 128)
    meas(8'h05, 8'h0A, 8'h01, per, x, g10);
    // Ten proc clocks of two frames of four DAC clocks
    `CHK("buffer delay", 80, g10 - g0)
    `CHK("release in multiframe", 1'b1, g10 < 128)
    meas(8'h05, 8'h0F, 8'h01, per, x, g15);
    `CHK("buffer clamp", g10, g15)
    meas(8'h05, 8'h00, 8'h00, per, x, h0);
    meas(8'h05, 8'h05, 8'h00, per, x, h5);
    // Half the proc clocks at F of one span the same time as ten at F of two
    `CHK("proc clock ratio", g10 - g0, h5 - h0)
    meas(8'h1A, 8'h00, 8'h01, per, ph26, x);
    `CHK("long local delay", 104, (ph26 - ph0 + 128) % 128)
  endtask : t_delays

  // ==========================================
  // Main sequence
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h00000000;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_oneshot();
    t_continuous();
    t_monitor();
    t_subclass0();
    t_delays();
    conclude();
  end
endmodule : lmfc_sync_and_link_delay_tb_top

// ==== verif/lsd_far_end.sv ====
`timescale 1ns/1ps
// ==========================================
// Far side: alignment edge source and link error source
module lsd_far_end
(
  input wire logic core_clk,
  output logic sysrefIn,
  output logic linkErrorIn
);
  int unsigned phase = 0;

  initial
  begin
    sysrefIn = 1'b0;
    linkErrorIn = 1'b0;
  end

  // Phase moves on the falling edge so it is stable at every rising edge
  always @(negedge core_clk)
    phase <= (phase + 1) % 128;

  // Held four clocks so the input synchroniser cannot miss it
  task automatic edge_at(input int unsigned ph);
    @(posedge core_clk);
    while (phase != ph)
      @(posedge core_clk);
    sysrefIn <= 1'b1;
    repeat (4) @(posedge core_clk);
    sysrefIn <= 1'b0;
  endtask : edge_at

  // Only the link error level is driven here; no lane alignment sequence is modelled
  task automatic set_error(input logic v);
    linkErrorIn <= v;
  endtask : set_error
endmodule : lsd_far_end
